// ### rtl/ddrpd_params.svh
`ifndef DDRPD_PARAMS_SVH
`define DDRPD_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DDRPD_OFF_CFG    8'h00
`define DDRPD_OFF_STAT   8'h04
`define DDRPD_OFF_WLO    8'h08
`define DDRPD_OFF_WHI    8'h0C
`define DDRPD_OFF_WEXT   8'h10
`define DDRPD_OFF_CMD    8'h14
`define DDRPD_OFF_RLO    8'h18
`define DDRPD_OFF_RHI    8'h1C
`define DDRPD_OFF_REXT   8'h20
`define DDRPD_OFF_RCNT   8'h24
`define DDRPD_CFG_RST    32'h0000_0000
// ----------------------------------------
// Command bits
// ----------------------------------------
`define DDRPD_CMD_GO     0
`define DDRPD_CMD_CLR    1
// ----------------------------------------
// Lanes and limits
// ----------------------------------------
`define DDRPD_LANES      36
`define DDRPD_DATA       32
`define DDRPD_EXT        4
`define DDRPD_MASKS      2
`define DDRPD_FAST_MHZ   8'd150
`define DDRPD_SLOW_MHZ   8'd133
`endif

// ### rtl/ddrpd_pkg.sv
package ddrpd_pkg;
   typedef enum logic [1:0] {
      DDRPD_X4  = 2'b00,
      DDRPD_X9  = 2'b01,
      DDRPD_X18 = 2'b10,
      DDRPD_X36 = 2'b11
   } ddrpd_mode_type;
   typedef enum logic [1:0] {
      DDRPD_DDR  = 2'b00,
      DDRPD_DDR2 = 2'b01,
      DDRPD_RLD2 = 2'b10,
      DDRPD_NONE = 2'b11
   } ddrpd_mem_type;
   typedef enum logic [1:0] {
      DDRPD_DIR_IN  = 2'b00,
      DDRPD_DIR_OUT = 2'b01,
      DDRPD_DIR_BI  = 2'b10,
      DDRPD_DIR_OFF = 2'b11
   } ddrpd_dir_type;
   typedef struct packed {
      logic [11:0]    spare;
      logic [7:0]     freq_mhz;
      logic           memclk_en;
      logic           fast_grade;
      logic           side_bank;
      ddrpd_dir_type  cstrobe_dir;
      logic           strobe_bidir;
      logic           dq_bidir;
      logic           ecc_en;
      ddrpd_mem_type  mem;
      ddrpd_mode_type mode;
   } ddrpd_cfg_type;
   typedef struct packed {
      logic [35:0] rise;
      logic [35:0] fall;
   } ddrpd_lane_type;
   typedef struct packed {
      logic [1:0] rise;
      logic [1:0] fall;
   } ddrpd_mask_type;
endpackage

// ### rtl/ddrpd_top.sv
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`include "ddrpd_params.svh"
module ddrpd_top
   import ddrpd_pkg::*;
(
   // System
   input  wire logic       mclk,
   input  wire logic       srst,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Link clock, the -90 degree write clock
   input  wire logic        lclk,
   // Data lanes
   output      ddrpd_lane_type dq_out,
   output      logic [35:0]    dq_oe,
   input  wire ddrpd_lane_type dq_in,
   // Mask lanes
   output      ddrpd_mask_type dm_out,
   output      logic [1:0]     dm_oe,
   // Strobes and memory clock
   output      logic [1:0]  strobe_out,
   output      logic        strobe_oe,
   output      logic [1:0]  strobe_complement_out,
   output      logic        strobe_complement_oe,
   output      logic [1:0]  memclk_out,
   output      logic [1:0]  memclk_n_out,
   // Read valid and phase shift
   input  wire logic        read_valid_input_pin,
   output      logic        phase_shift_en
);
   // ----------------------------------------
   // Lane decoding
   // ----------------------------------------
   function automatic logic [35:0] lane_en(input ddrpd_mode_type m);
      logic [35:0] e;
      e = 36'h0_0000_0000;
      case (m)
         DDRPD_X4:  e = 36'h0_0000_000F;
         DDRPD_X9:  e = 36'h1_0000_00FF;
         DDRPD_X18: e = 36'h3_0000_FFFF;
         DDRPD_X36: e = 36'hF_FFFF_FFFF;
         default:   e = 36'h0_0000_0000;
      endcase
      return e;
   endfunction

   function automatic logic [3:0] byte_par(input logic [31:0] d);
      logic [3:0] p;
      p = 4'h0;
      for (int i = 0; i < 4; i++) begin
         p[i] = ^d[i*8 +: 8];
      end
      return p;
   endfunction

   // ----------------------------------------
   // Bus side registers
   // ----------------------------------------
   ddrpd_cfg_type cfg_q;
   logic [31:0]   wlo_q;
   logic [31:0]   whi_q;
   logic [31:0]   wext_q;
   logic [31:0]   rlo_q;
   logic [31:0]   rhi_q;
   logic [31:0]   rext_q;
   logic [31:0]   rcnt_q;
   logic          req_q;
   logic          rd_avail_q;
   logic          refused_q;
   logic          aw_full_q;
   logic          w_full_q;
   logic          bvalid_q;
   logic          rvalid_q;
   logic [7:0]    awaddr_q;
   logic [31:0]   wdata_q;
   logic [31:0]   rdata_q;
   logic [1:0]    bresp_q;
   logic [1:0]    rresp_q;
   logic [1:0]    ack_s_q;
   logic [1:0]    rtog_s_q;
   logic          rtog_seen_q;
   // Link-side toggles, read here through two-stage synchronisers
   logic          ack_q;
   logic          rtog_q;

   // ----------------------------------------
   // Decode and status
   // ----------------------------------------
   wire        busy     = req_q != ack_s_q[1];
   wire [7:0]  lim_mhz  = cfg_q.fast_grade ? `DDRPD_FAST_MHZ : `DDRPD_SLOW_MHZ;
   wire        rate_ok  = !cfg_q.side_bank || (cfg_q.freq_mhz <= lim_mhz);
   wire        do_wr    = aw_full_q && w_full_q && !bvalid_q;
   wire        do_rd    = s_axi_arvalid && !rvalid_q;
   wire        wr_cfg   = do_wr && awaddr_q == `DDRPD_OFF_CFG;
   wire        wr_wlo   = do_wr && awaddr_q == `DDRPD_OFF_WLO && !busy;
   wire        wr_whi   = do_wr && awaddr_q == `DDRPD_OFF_WHI && !busy;
   wire        wr_wext  = do_wr && awaddr_q == `DDRPD_OFF_WEXT && !busy;
   wire        wr_cmd   = do_wr && awaddr_q == `DDRPD_OFF_CMD;
   wire        go       = wr_cmd && wdata_q[`DDRPD_CMD_GO];
   wire        clr      = wr_cmd && wdata_q[`DDRPD_CMD_CLR];
   wire        launch   = go && !busy && rate_ok;
   wire        refuse   = go && !launch;
   wire        wr_map   = awaddr_q <= `DDRPD_OFF_CMD && awaddr_q[1:0] == 2'b00;
   wire        rd_new   = rtog_s_q[1] != rtog_seen_q;
   wire        ps_en    = cfg_q.dq_bidir && cfg_q.strobe_bidir;
   wire [31:0] stat_w   = {27'h0, refused_q, rd_avail_q, rate_ok, ps_en, busy};
   wire [31:0] wfull    = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                           {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   wire [31:0] cfg_w    = (cfg_q & ~wfull) | (s_axi_wdata & wfull);

   // Unmapped reads answer with an error and zero data
   logic [31:0] rd_mux;
   logic        rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `DDRPD_OFF_CFG:  rd_mux = cfg_q;
         `DDRPD_OFF_STAT: rd_mux = stat_w;
         `DDRPD_OFF_WLO:  rd_mux = wlo_q;
         `DDRPD_OFF_WHI:  rd_mux = whi_q;
         `DDRPD_OFF_WEXT: rd_mux = wext_q;
         `DDRPD_OFF_CMD:  rd_mux = 32'h0000_0000;
         `DDRPD_OFF_RLO:  rd_mux = rlo_q;
         `DDRPD_OFF_RHI:  rd_mux = rhi_q;
         `DDRPD_OFF_REXT: rd_mux = rext_q;
         `DDRPD_OFF_RCNT: rd_mux = rcnt_q;
         default: begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // Strobes are merged into the masked word before the write ends
   logic [31:0] cfg_hold;
   always_comb begin
      cfg_hold = wdata_q;
   end

   // ----------------------------------------
   // AXI handshake
   // ----------------------------------------
   // Address and data may arrive in either order; each waits in its own slot
   always_ff @(posedge mclk) begin
      if (srst) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         rvalid_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         rdata_q   <= 32'h0000_0000;
         bresp_q   <= 2'b00;
         rresp_q   <= 2'b00;
      end else begin
         if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            wdata_q  <= cfg_w;
         end
         if (do_wr) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_map ? 2'b00 : 2'b10;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         if (do_rd) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? 2'b00 : 2'b10;
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         cfg_q       <= `DDRPD_CFG_RST;
         wlo_q       <= 32'h0000_0000;
         whi_q       <= 32'h0000_0000;
         wext_q      <= 32'h0000_0000;
         req_q       <= 1'b0;
         refused_q   <= 1'b0;
         rd_avail_q  <= 1'b0;
      end else begin
         if (wr_cfg) cfg_q <= cfg_hold;
         // Pattern writes are dropped while a beat is in flight, so the link sees stable words
         if (wr_wlo) wlo_q <= cfg_hold;
         if (wr_whi) whi_q <= cfg_hold;
         if (wr_wext) wext_q <= cfg_hold;
         if (launch) req_q <= !req_q;
         // An event in the clearing cycle still sets its flag
         refused_q  <= refuse || (refused_q && !clr);
         rd_avail_q <= rd_new || (rd_avail_q && !clr);
      end
   end

   // ----------------------------------------
   // Read words into the bus domain
   // ----------------------------------------
   // The word stays put until the next capture, so a toggle handshake is enough
   logic [71:0] rword_q;
   always_ff @(posedge mclk) begin
      if (srst) begin
         ack_s_q     <= 2'b00;
         rtog_s_q    <= 2'b00;
         rtog_seen_q <= 1'b0;
         rlo_q       <= 32'h0000_0000;
         rhi_q       <= 32'h0000_0000;
         rext_q      <= 32'h0000_0000;
         rcnt_q      <= 32'h0000_0000;
      end else begin
         ack_s_q  <= {ack_s_q[0], ack_q};
         rtog_s_q <= {rtog_s_q[0], rtog_q};
         if (rd_new) begin
            rtog_seen_q <= rtog_s_q[1];
            rlo_q  <= rword_q[31:0];
            rhi_q  <= rword_q[67:36];
            rext_q <= {24'h0, rword_q[71:68], rword_q[35:32]};
            rcnt_q <= rcnt_q + 32'h0000_0001;
         end
      end
   end

   // ----------------------------------------
   // Link domain
   // ----------------------------------------
   logic [1:0]     lrst_s_q;
   logic [1:0]     req_s_q;
   logic           lrst;
   logic           req_seen_q;
   ddrpd_cfg_type  lcfg_m_q;
   ddrpd_cfg_type  lcfg_q;
   ddrpd_lane_type dqi_m_q;
   ddrpd_lane_type dqi_q;
   logic           rv_m_q;
   logic           rv_q;
   logic           rv_d1_q;

   assign lrst = lrst_s_q[1];

   // Quasi-static settings; software changes them only while idle
   always_ff @(posedge lclk) begin
      lrst_s_q <= {lrst_s_q[0], srst};
      lcfg_m_q <= cfg_q;
      lcfg_q   <= lcfg_m_q;
      req_s_q  <= {req_s_q[0], req_q};
      dqi_m_q  <= dq_in;
      dqi_q    <= dqi_m_q;
      rv_m_q   <= read_valid_input_pin;
      rv_q     <= rv_m_q;
   end

   // ----------------------------------------
   // Link decode
   // ----------------------------------------
   wire        l_go    = req_s_q[1] != req_seen_q;
   wire [35:0] l_en    = lane_en(lcfg_q.mode);
   wire        l_wide  = lcfg_q.mode != DDRPD_X4;
   wire        l_mask  = lcfg_q.mem != DDRPD_NONE;
   wire        l_rld   = lcfg_q.mem == DDRPD_RLD2;
   // Check bits come in from the controller; parity is the only coding here
   wire [3:0]  ext_r   = lcfg_q.ecc_en ? wext_q[3:0] : byte_par(wlo_q);
   wire [3:0]  ext_f   = lcfg_q.ecc_en ? wext_q[7:4] : byte_par(whi_q);
   wire [35:0] dq_en   = lcfg_q.dq_bidir ? l_en & {{4{l_wide}}, 32'hFFFF_FFFF} : 36'h0;
   wire [1:0]  dm_en   = l_rld ? 2'b11 : 2'b01;
   wire        cs_out  = lcfg_q.cstrobe_dir == DDRPD_DIR_OUT ||
                         lcfg_q.cstrobe_dir == DDRPD_DIR_BI;

   always_ff @(posedge lclk) begin
      if (lrst) begin
         req_seen_q           <= 1'b0;
         ack_q                <= 1'b0;
         dq_out               <= '0;
         dq_oe                <= 36'h0_0000_0000;
         dm_out               <= '0;
         dm_oe                <= 2'b00;
         strobe_out           <= 2'b00;
         strobe_oe            <= 1'b0;
         strobe_complement_out <= 2'b00;
         strobe_complement_oe <= 1'b0;
         memclk_out           <= 2'b00;
         memclk_n_out         <= 2'b00;
      end else begin
         req_seen_q <= req_s_q[1];
         if (l_go) ack_q <= !ack_q;
         // One write beat per launch, both halves from DDR output registers
         dq_out.rise <= {ext_r, wlo_q} & l_en;
         dq_out.fall <= {ext_f, whi_q} & l_en;
         dq_oe       <= l_go ? dq_en : 36'h0_0000_0000;
         // High mask bit blanks the beat at the memory
         dm_out.rise <= wext_q[9:8] & dm_en;
         dm_out.fall <= wext_q[11:10] & dm_en;
         dm_oe       <= (l_go && l_mask) ? dm_en : 2'b00;
         // Separate single-ended drivers for the two strobes
         strobe_out  <= 2'b10;
         strobe_oe   <= l_go && lcfg_q.strobe_bidir;
         strobe_complement_out <= 2'b01;
         strobe_complement_oe  <= l_go && cs_out;
         memclk_out   <= lcfg_q.memclk_en ? 2'b10 : 2'b00;
         memclk_n_out <= lcfg_q.memclk_en ? 2'b01 : 2'b00;
      end
   end

   // ----------------------------------------
   // Read capture
   // ----------------------------------------
   // Valid leads data by one cycle, so the word a cycle later is qualified
   always_ff @(posedge lclk) begin
      if (lrst) begin
         rv_d1_q <= 1'b0;
         rtog_q  <= 1'b0;
         rword_q <= 72'h0;
      end else begin
         rv_d1_q <= rv_q;
         // Words seen with valid low are dropped
         if (rv_d1_q && !dq_oe[0]) begin
            rtog_q  <= !rtog_q;
            rword_q <= {dqi_q.fall, dqi_q.rise};
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign s_axi_awready  = !aw_full_q;
   assign s_axi_wready   = !w_full_q;
   assign s_axi_bvalid   = bvalid_q;
   assign s_axi_bresp    = bresp_q;
   assign s_axi_arready  = !rvalid_q;
   assign s_axi_rvalid   = rvalid_q;
   assign s_axi_rdata    = rdata_q;
   assign s_axi_rresp    = rresp_q;
   assign phase_shift_en = ps_en;
endmodule

// ### verif/ddrpd_top_monitor.sv
module ddrpd_mon
   import ddrpd_pkg::*;
(
   // Clocks and reset
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic        lclk,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   // Memory pins
   input wire logic [35:0] dq_oe,
   input wire logic [1:0]  dm_oe,
   input wire logic [1:0]  strobe_out,
   input wire logic        strobe_oe,
   input wire logic [1:0]  strobe_complement_out,
   input wire logic        strobe_complement_oe,
   input wire logic [1:0]  memclk_out,
   input wire logic [1:0]  memclk_n_out,
   input wire logic        phase_shift_en
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence stat_read;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04;
   endsequence
   sequence beat_start;
      $rose(|dq_oe);
   endsequence
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   wr_resp_a: assert property (@(posedge mclk) disable iff (srst)
      wr_taken |-> ##[1:2] s_axi_bvalid) else $error("write response late");
   rd_resp_a: assert property (@(posedge mclk) disable iff (srst)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read response late");
   phase_stat_a: assert property (@(posedge mclk) disable iff (srst)
      stat_read |=> s_axi_rdata[1] == phase_shift_en) else $error("phase status wrong");
   mask_write_a: assert property (@(posedge lclk) disable iff (srst)
      |dm_oe |-> |dq_oe) else $error("mask driven outside write");
   mask_group_a: assert property (@(posedge lclk) disable iff (srst)
      dm_oe[1] |-> dm_oe[0]) else $error("mask lanes out of order");
   beat_pulse_a: assert property (@(posedge lclk) disable iff (srst)
      beat_start |=> dq_oe == 36'h0) else $error("beat longer than one cycle");
   strobe_se_a: assert property (@(posedge lclk) disable iff (srst)
      strobe_oe |-> strobe_out == 2'h2 && |dq_oe) else $error("strobe wrong");
   cstrobe_a: assert property (@(posedge lclk) disable iff (srst)
      strobe_complement_oe |-> strobe_complement_out == 2'h1 && |dq_oe)
      else $error("complement strobe wrong");
   memclk_a: assert property (@(posedge lclk) disable iff (srst)
      memclk_out != 2'h0 |-> memclk_out == 2'h2 && memclk_n_out == 2'h1)
      else $error("memory clock wrong");
endmodule

bind ddrpd_top ddrpd_mon i_ddrpd_mon (.*);

// ### verif/ddrpd_mem.sv
module ddrpd_mem
   import ddrpd_pkg::*;
(
   // Link clock
   input  wire logic           lclk,
   // Write side
   input  wire ddrpd_lane_type dq_out,
   input  wire logic [35:0]    dq_oe,
   input  wire ddrpd_mask_type dm_out,
   input  wire logic [1:0]     dm_oe,
   input  wire logic           strobe_oe,
   input  wire logic           strobe_complement_oe,
   // Read side
   output      ddrpd_lane_type dq_in,
   output      logic           read_valid_input_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int             beats = 0;
   ddrpd_lane_type b_lane;
   logic [35:0]    b_oe;
   logic [1:0]     b_dmoe;
   logic [1:0]     b_so;
   logic [35:0]    kept = 36'h0;
   initial begin
      dq_in = 72'h0;
      read_valid_input_pin = 1'b0;
   end
   // Mask and data are sampled on the same write clock edge
   always @(posedge lclk) begin
      if (|dq_oe) begin
         beats <= beats + 1;
         b_lane <= dq_out;
         b_oe <= dq_oe;
         b_dmoe <= dm_oe;
         b_so <= {strobe_oe, strobe_complement_oe};
         if (!(dm_oe[0] && dm_out.rise[0])) begin
            kept <= dq_out.rise;
         end
      end
   end
   // Valid leads the word by one cycle; released lines never hold the word
   task automatic send(input ddrpd_lane_type w, input logic v);
      @(posedge lclk);
      read_valid_input_pin <= v;
      @(posedge lclk);
      read_valid_input_pin <= 1'b0;
      dq_in <= w;
      @(posedge lclk);
      dq_in <= ~w;
   endtask
endmodule

// ### verif/ddr_memory_pin_datapath_tb.sv
`include "ddrpd_params.svh"
module ddr_memory_pin_datapath_tb
   import ddrpd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic           mclk = 1'b0, lclk = 1'b0, srst = 1'b1;
   logic [7:0]     s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0]    s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]     s_axi_wstrb = 4'hF;
   logic           s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic           s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]     s_axi_bresp, s_axi_rresp, dm_oe, strobe_out, strobe_complement_out;
   logic [1:0]     memclk_out, memclk_n_out;
   logic           strobe_oe, strobe_complement_oe, phase_shift_en, read_valid_input_pin;
   logic [35:0]    dq_oe;
   ddrpd_lane_type dq_out, dq_in;
   ddrpd_mask_type dm_out;
   int             fails = 0, checks = 0;
   always #25 mclk = ~mclk;
   always #7.5 lclk = ~lclk;
   ddrpd_top i_ddrpd_top (.*);
   ddrpd_mem i_ddrpd_mem (.*);
   // ----------------------------------------
   // Bus and compare tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [71:0] e, input logic [71:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge mclk);
         if (s_axi_awvalid && s_axi_awready) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            dd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge mclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge mclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task automatic wok(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk("bresp", 2'h0, r);
   endtask
   task automatic rget(input logic [7:0] a, output logic [31:0] d);
      logic [1:0] r;
      rd(a, d, r);
      chk("rresp", 2'h0, r);
   endtask
   function automatic logic [35:0] lanes(input logic [31:0] d);
      for (int i = 0; i < 4; i++) lanes[32+i] = ^d[8*i+:8];
      lanes[31:0] = d;
   endfunction
   // Config only changes while idle, so each launch waits for busy to drop
   task automatic beat(input logic [31:0] c, input logic [31:0] lo, input logic [31:0] hi,
                       input logic [31:0] ext);
      logic [31:0] s;
      int          b;
      wok(`DDRPD_OFF_CFG, c);
      wok(`DDRPD_OFF_WLO, lo);
      wok(`DDRPD_OFF_WHI, hi);
      wok(`DDRPD_OFF_WEXT, ext);
      b = i_ddrpd_mem.beats;
      wok(`DDRPD_OFF_CMD, 32'h1);
      do rget(`DDRPD_OFF_STAT, s); while (s[0]);
      chk("beats", b + 1, i_ddrpd_mem.beats);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      rget(`DDRPD_OFF_CFG, d);
      chk("cfg_reset", `DDRPD_CFG_RST, d);
      rd(8'h28, d, r);
      chk("rd_unmapped", 2'h2, r);
      wr(8'h2C, 32'h1, r);
      chk("wr_unmapped", 2'h2, r);
   endtask
   task automatic t_wide;
      beat(32'h8E3, 32'hA5C3_0F01, 32'h1234_5678, 32'h0);
      chk("rise", lanes(32'hA5C3_0F01), i_ddrpd_mem.b_lane.rise);
      chk("fall", lanes(32'h1234_5678), i_ddrpd_mem.b_lane.fall);
      chk("lane_oe", 36'hF_FFFF_FFFF, i_ddrpd_mem.b_oe);
      chk("mask_oe", 2'h1, i_ddrpd_mem.b_dmoe);
      chk("strobe_oe", 2'h3, i_ddrpd_mem.b_so);
      chk("phase_on", 1'b1, phase_shift_en);
      chk("memclk", 4'h9, {memclk_out, memclk_n_out});
      beat(32'h8E3, 32'h0000_FFFF, 32'h0, 32'h100);
      chk("masked", lanes(32'hA5C3_0F01), i_ddrpd_mem.kept);
      beat(32'h8F3, 32'h0, 32'h0, 32'h5A);
      chk("ecc_rise", 4'hA, i_ddrpd_mem.b_lane.rise[35:32]);
      chk("ecc_fall", 4'h5, i_ddrpd_mem.b_lane.fall[35:32]);
   endtask
   task automatic t_narrow;
      beat(32'h828, 32'hFFFF_FFFF, 32'h0, 32'h0);
      chk("rld_mask", 2'h3, i_ddrpd_mem.b_dmoe);
      chk("in_only", 2'h0, i_ddrpd_mem.b_so);
      chk("x4_parity", 4'h0, i_ddrpd_mem.b_oe[35:32]);
      chk("phase_off", 1'b0, phase_shift_en);
   endtask
   task automatic t_read;
      logic [31:0]    n, d;
      ddrpd_lane_type w;
      w = {36'h9_0F0F_1234, 36'h6_A5A5_0001};
      rget(`DDRPD_OFF_RCNT, n);
      i_ddrpd_mem.send(w, 1'b1);
      do rget(`DDRPD_OFF_RCNT, d); while (d == n);
      rget(`DDRPD_OFF_RLO, d);
      chk("rlo", w.rise[31:0], d);
      rget(`DDRPD_OFF_RHI, d);
      chk("rhi", w.fall[31:0], d);
      rget(`DDRPD_OFF_REXT, d);
      chk("rext", {24'h0, w.fall[35:32], w.rise[35:32]}, d);
      rget(`DDRPD_OFF_STAT, d);
      chk("avail", 1'b1, d[3]);
      i_ddrpd_mem.send(~w, 1'b0);
      repeat (20) @(posedge mclk);
      rget(`DDRPD_OFF_RLO, d);
      chk("unqualified", w.rise[31:0], d);
      rget(`DDRPD_OFF_RCNT, d);
      chk("rcnt_once", n + 32'h1, d);
      wok(`DDRPD_OFF_CMD, 32'h2);
      rget(`DDRPD_OFF_STAT, d);
      chk("avail_clr", 1'b0, d[3]);
   endtask
   task automatic t_rate;
      logic [7:0]  f [4] = '{8'h96, 8'h97, 8'h85, 8'h86};
      logic [31:0] s;
      for (int i = 0; i < 4; i++) begin
         wok(`DDRPD_OFF_CFG, 32'hAE3 | {21'h0, i < 2, 10'h0} | {12'h0, f[i], 12'h0});
         wok(`DDRPD_OFF_CMD, 32'h2);
         wok(`DDRPD_OFF_CMD, 32'h1);
         rget(`DDRPD_OFF_STAT, s);
         chk("rate_ok", !i[0], s[2]);
         chk("refused", i[0], s[4]);
         do rget(`DDRPD_OFF_STAT, s); while (s[0]);
      end
   endtask
   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task automatic stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #2_000_000;
      fails++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      repeat (2) @(posedge mclk);
      t_reset();
      t_wide();
      t_narrow();
      t_read();
      t_rate();
      stop_test();
   end
endmodule
